//--- hw/idpb_pkg.sv
package idpb_pkg;

  // ------------------------------------------------------------
  // block geometry
  // ------------------------------------------------------------
  localparam int unsigned WORDS_PER_BLOCK = 256;
  localparam int unsigned SERIAL_FIRST    = 10;
  localparam int unsigned SERIAL_CHARS    = 20;
  localparam int unsigned FWREV_FIRST     = 23;
  localparam int unsigned FWREV_CHARS     = 8;
  localparam int unsigned MODEL_FIRST     = 27;
  localparam int unsigned MODEL_CHARS     = 40;

  // ------------------------------------------------------------
  // word indices
  // ------------------------------------------------------------
  localparam logic [7:0] W_GENCFG   = 8'h00;
  localparam logic [7:0] W_MULTMAX  = 8'h2F;
  localparam logic [7:0] W_CAPS     = 8'h31;
  localparam logic [7:0] W_VALID    = 8'h35;
  localparam logic [7:0] W_CYLS     = 8'h36;
  localparam logic [7:0] W_HEADS    = 8'h37;
  localparam logic [7:0] W_SPT      = 8'h38;
  localparam logic [7:0] W_CURCAP_L = 8'h39;
  localparam logic [7:0] W_CURCAP_H = 8'h3A;
  localparam logic [7:0] W_MULTCUR  = 8'h3B;
  localparam logic [7:0] W_TOTAL_L  = 8'h3C;
  localparam logic [7:0] W_TOTAL_H  = 8'h3D;
  localparam logic [7:0] W_MWDMA    = 8'h3F;
  localparam logic [7:0] W_PIO      = 8'h40;
  localparam logic [7:0] W_MWCYCMIN = 8'h41;
  localparam logic [7:0] W_MWCYCREC = 8'h42;
  localparam logic [7:0] W_PIOCYC   = 8'h43;
  localparam logic [7:0] W_PIOCYCRD = 8'h44;
  localparam logic [7:0] W_OVLP0    = 8'h45;
  localparam logic [7:0] W_OVLP1    = 8'h46;
  localparam logic [7:0] W_QDEPTH   = 8'h4B;
  localparam logic [7:0] W_MAJOR    = 8'h50;
  localparam logic [7:0] W_MINOR    = 8'h51;
  localparam logic [7:0] W_CMDSET0  = 8'h52;
  localparam logic [7:0] W_CMDSET1  = 8'h53;
  localparam logic [7:0] W_CMDEXT   = 8'h54;
  localparam logic [7:0] W_UDMA     = 8'h58;

  // ------------------------------------------------------------
  // fixed word values
  // ------------------------------------------------------------
  localparam logic [15:0] V_GENCFG   = 16'h044A;
  localparam logic [7:0]  V_MULT_TAG = 8'h80;
  localparam logic [15:0] V_CAPS     = 16'h0F00;
  localparam logic [15:0] V_VALID    = 16'h0007;
  localparam logic [7:0]  V_MULT_OK  = 8'h01;
  localparam logic [7:0]  V_MW_SUPP  = 8'h07;
  localparam logic [15:0] V_PIO      = 16'h0003;
  localparam logic [15:0] V_CYCLE_NS = 16'h0078;
  localparam logic [15:0] V_ZERO     = 16'h0000;
  localparam logic [15:0] V_MAJOR    = 16'h0080;
  localparam logic [15:0] V_CMDSET0  = 16'h742B;
  localparam logic [15:0] V_CMDSET1  = 16'h5100;
  localparam logic [15:0] V_CMDEXT   = 16'h4003;
  localparam logic [7:0]  V_UDMA_SUP = 8'h7F;
  localparam logic [7:0]  ASCII_SPACE = 8'h20;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    IDPB_IDLE,
    IDPB_SEND
  } idpb_state_e;

  typedef struct packed {
    logic [15:0] cylinders;
    logic [15:0] heads;
    logic [15:0] sectors_per_track;
    logic [31:0] current_capacity;
    logic [31:0] total_sectors;
    logic [7:0]  multiple_max;
    logic [7:0]  multiple_current;
    logic        multiple_valid;
    logic [2:0]  mwdma_selected;
    logic [6:0]  udma_selected;
  } idpb_geom_s;

  typedef struct packed {
    logic        ready;
    logic [15:0] data;
    logic        last;
  } idpb_word_s;

endpackage : idpb_pkg

//--- hw/idpb_block.sv
`timescale 1ns/1ps
// Contract
// - serial string, 20 ASCII chars, occupies words 10 to 19
// - firmware revision, 8 ASCII chars, occupies words 23 to 26
// - model string, 40 ASCII chars, occupies words 27 to 46
// - word 47: upper byte 80h, lower byte max sectors per interrupt
// - word 49 reports IORDY, IORDY disable, LBA, DMA: 0F00h
// - word 53 flags words 88 and 64-70 valid: 0007h
// - words 54-56 give current cylinders, heads, sectors per track
// - words 57-58 give current capacity in sectors
// - word 59: bit 8 multiple valid, low byte current setting
// - words 60-61 give total addressable sectors
// - word 63: selected multiword DMA in 10:8, supported 07h low
// - word 64 reports advanced PIO modes 0003h
// - words 65-68 report cycle times of 0078h nanoseconds
// - queue depth word reports 0000h
// - word 80 major version bit map 0080h
// - word 81 minor version 0000h
// - word 82 supported command sets 742Bh
// - word 83 command sets 5100h
// - word 84 extended command sets 4003h
// - words 69 and 70 read as zero
// - identify command sends block like single-sector read
// - every reserved bit and word reads zero
// - word 88 upper byte marks selected Ultra DMA mode
module idpb_block
  import idpb_pkg::*;
#(
  parameter int unsigned WORD_COUNT = WORDS_PER_BLOCK
) (
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  input  wire logic                         identify_start,
  input  wire logic                         word_take,
  input  wire idpb_geom_s                   geom,
  input  wire logic [SERIAL_CHARS*8-1:0]    serial_str,
  input  wire logic [FWREV_CHARS*8-1:0]     fwrev_str,
  input  wire logic [MODEL_CHARS*8-1:0]     model_str,
  output idpb_word_s                        word_out,
  output logic                              busy
);

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (WORD_COUNT != WORDS_PER_BLOCK || WORD_COUNT > 256) begin : g_bad_count
    $error("idpb_block: WORD_COUNT must equal one sector of words");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    idpb_state_e state;
    logic [7:0]  index;
    logic [15:0] data;
    logic        ready;
  } idpb_regs_s;

  idpb_regs_s r_q;
  idpb_regs_s r_d;

  // ------------------------------------------------------------
  // string packing
  // ------------------------------------------------------------
  // chars are given leftmost first in the top byte; a zero byte becomes space
  function automatic logic [7:0] idpb_char(input logic [7:0] c);
    idpb_char = (c == 8'h00) ? ASCII_SPACE : c;
  endfunction : idpb_char

  function automatic logic [15:0] idpb_pair(input logic [7:0] first, input logic [7:0] second);
    idpb_pair = {idpb_char(first), idpb_char(second)};
  endfunction : idpb_pair

  // ------------------------------------------------------------
  // word content
  // ------------------------------------------------------------
  function automatic logic [15:0] idpb_word(
    input logic [7:0]                      idx,
    input idpb_geom_s                      g,
    input logic [SERIAL_CHARS*8-1:0]       sn,
    input logic [FWREV_CHARS*8-1:0]        fw,
    input logic [MODEL_CHARS*8-1:0]        mn
  );
    int unsigned k;
    k         = 0;
    idpb_word = V_ZERO;
    if (idx >= 8'(SERIAL_FIRST) && idx < 8'(SERIAL_FIRST + SERIAL_CHARS / 2)) begin
      k         = 32'(idx) - SERIAL_FIRST;
      idpb_word = idpb_pair(sn[SERIAL_CHARS*8-1-16*k -: 8], sn[SERIAL_CHARS*8-9-16*k -: 8]);
    end else if (idx >= 8'(FWREV_FIRST) && idx < 8'(FWREV_FIRST + FWREV_CHARS / 2)) begin
      k         = 32'(idx) - FWREV_FIRST;
      idpb_word = idpb_pair(fw[FWREV_CHARS*8-1-16*k -: 8], fw[FWREV_CHARS*8-9-16*k -: 8]);
    end else if (idx >= 8'(MODEL_FIRST) && idx < 8'(MODEL_FIRST + MODEL_CHARS / 2)) begin
      k         = 32'(idx) - MODEL_FIRST;
      idpb_word = idpb_pair(mn[MODEL_CHARS*8-1-16*k -: 8], mn[MODEL_CHARS*8-9-16*k -: 8]);
    end else begin
      unique case (idx)
        W_GENCFG:   idpb_word = V_GENCFG;
        W_MULTMAX:  idpb_word = {V_MULT_TAG, g.multiple_max};
        W_CAPS:     idpb_word = V_CAPS;
        W_VALID:    idpb_word = V_VALID;
        W_CYLS:     idpb_word = g.cylinders;
        W_HEADS:    idpb_word = g.heads;
        W_SPT:      idpb_word = g.sectors_per_track;
        W_CURCAP_L: idpb_word = g.current_capacity[15:0];
        W_CURCAP_H: idpb_word = g.current_capacity[31:16];
        W_MULTCUR:  idpb_word = {7'h00, g.multiple_valid, g.multiple_current};
        W_TOTAL_L:  idpb_word = g.total_sectors[15:0];
        W_TOTAL_H:  idpb_word = g.total_sectors[31:16];
        W_MWDMA:    idpb_word = {5'h00, g.mwdma_selected, V_MW_SUPP};
        W_PIO:      idpb_word = V_PIO;
        W_MWCYCMIN: idpb_word = V_CYCLE_NS;
        W_MWCYCREC: idpb_word = V_CYCLE_NS;
        W_PIOCYC:   idpb_word = V_CYCLE_NS;
        W_PIOCYCRD: idpb_word = V_CYCLE_NS;
        W_OVLP0:    idpb_word = V_ZERO;
        W_OVLP1:    idpb_word = V_ZERO;
        W_QDEPTH:   idpb_word = V_ZERO;
        W_MAJOR:    idpb_word = V_MAJOR;
        W_MINOR:    idpb_word = V_ZERO;
        W_CMDSET0:  idpb_word = V_CMDSET0;
        W_CMDSET1:  idpb_word = V_CMDSET1;
        W_CMDEXT:   idpb_word = V_CMDEXT;
        W_UDMA:     idpb_word = {1'b0, g.udma_selected, V_UDMA_SUP};
        default:    idpb_word = V_ZERO;
      endcase
    end
  endfunction : idpb_word

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // data is held in a flop one word ahead so word_out.data never glitches
  always_comb begin
    r_d = r_q;
    unique case (r_q.state)
      IDPB_IDLE: begin
        if (identify_start) begin
          r_d.state = IDPB_SEND;
          r_d.index = 8'h00;
          r_d.data  = idpb_word(8'h00, geom, serial_str, fwrev_str, model_str);
          r_d.ready = 1'b1;
        end
      end
      IDPB_SEND: begin
        if (word_take) begin
          if (r_q.index == 8'(WORD_COUNT - 1)) begin
            r_d.state = IDPB_IDLE;
            r_d.ready = 1'b0;
            r_d.index = 8'h00;
            r_d.data  = V_ZERO;
          end else begin
            r_d.index = r_q.index + 8'h01;
            r_d.data  = idpb_word(r_q.index + 8'h01, geom, serial_str, fwrev_str, model_str);
          end
        end
      end
      default: begin
        r_d.state = IDPB_IDLE;
        r_d.ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r_q <= '{state: IDPB_IDLE, index: 8'h00, data: 16'h0000, ready: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign word_out.ready = r_q.ready;
  assign word_out.data  = r_q.data;
  assign word_out.last  = r_q.ready && (r_q.index == 8'(WORD_COUNT - 1));
  assign busy           = (r_q.state == IDPB_SEND);

endmodule : idpb_block

//--- verification/idpb_block_assertions.sv
`timescale 1ns/1ps
module idpb_block_assertions
  import idpb_pkg::*;
#(
  parameter int unsigned WORD_COUNT = 256
) (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       identify_start,
  input wire logic       word_take,
  input wire idpb_geom_s geom,
  input wire idpb_word_s word_out,
  input wire logic       busy
);
  // ------------------------------------------------------------
  // word index tracker
  // ------------------------------------------------------------
  logic [8:0] cnt_q;
  always_ff @(posedge ref_clk) begin
    if (reset || !busy) cnt_q <= 9'h000;
    else if (word_out.ready && word_take) cnt_q <= cnt_q + 9'h001;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence start_s; identify_start && !busy; endsequence
  sequence take_last_s; word_out.ready && word_out.last && word_take; endsequence
  property word_is(int n, logic [15:0] v);
    word_out.ready && cnt_q == n |-> word_out.data == v;
  endproperty
  start_answer_a: assert property (start_s |=> word_out.ready && busy && word_out.data == 16'h044A)
    else $error("first word missing after start");
  hold_word_a: assert property (word_out.ready && !word_take |=> word_out.ready && $stable(word_out.data))
    else $error("word changed before take");
  block_end_a: assert property (take_last_s |=> !word_out.ready && !busy)
    else $error("send did not end after last word");
  last_flag_a: assert property (word_out.ready |-> word_out.last == (cnt_q == WORD_COUNT - 1))
    else $error("last flag on wrong word");
  mult_max_a: assert property (word_is(47, {8'h80, geom.multiple_max}))
    else $error("word 47 wrong");
  caps_word_a: assert property (word_is(49, 16'h0F00))
    else $error("word 49 wrong");
  valid_word_a: assert property (word_is(53, 16'h0007))
    else $error("word 53 wrong");
  cap_low_a: assert property (word_is(57, geom.current_capacity[15:0]))
    else $error("word 57 wrong");
  mult_cur_a: assert property (word_is(59, {7'h00, geom.multiple_valid, geom.multiple_current}))
    else $error("word 59 wrong");
  total_high_a: assert property (word_is(61, geom.total_sectors[31:16]))
    else $error("word 61 wrong");
  overlap_zero_a: assert property (word_is(69, 16'h0000))
    else $error("word 69 not zero");
endmodule : idpb_block_assertions

//--- verification/idpb_host.sv
`timescale 1ns/1ps
module idpb_host
  import idpb_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       slow,
  input wire idpb_word_s word_out,
  output logic           word_take = 1'b0
);
  logic [15:0] words_q [256];
  logic [7:0]  n_q;
  logic [1:0]  ph_q;
  // slow mode takes in bursts of two with gaps, like a stalling host
  always @(posedge ref_clk) begin
    if (reset) begin
      word_take <= 1'b0;
      n_q       <= 8'h00;
      ph_q      <= 2'h0;
    end else begin
      ph_q      <= ph_q + 2'h1;
      word_take <= slow ? ph_q[1] : 1'b1;
      if (word_take && word_out.ready) begin
        words_q[n_q] <= word_out.data;
        n_q          <= n_q + 8'h01;
      end
    end
  end
endmodule : idpb_host

//--- verification/tb.sv
`timescale 1ns/1ps
module tb
  import idpb_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         reset = 1'b1;
  logic         identify_start = 1'b0;
  logic         host_slow = 1'b0;
  logic         word_take;
  logic         busy;
  idpb_word_s   word_out;
  idpb_geom_s   geom = '{16'h1E2D, 16'h0010, 16'h003F, 32'h0076_5432, 32'h0098_ABCD, 8'h01, 8'h01, 1'b1, 3'h4, 7'h20};
  logic [159:0] serial_str = {"ABCDEFGHIJKLMNOPQR", 16'h0000};
  logic [63:0]  fwrev_str = "FW1.0.7A";
  logic [319:0] model_str = {"FLASH CARD X", 224'h0};
  int           fail_count = 0;
  int           num_checks = 0;
  localparam logic [23:0] ROWS [28] = '{24'h00044A, 24'h2F8001, 24'h310F00, 24'h350007, 24'h361E2D, 24'h370010,
    24'h38003F, 24'h395432, 24'h3A0076, 24'h3B0101, 24'h3CABCD, 24'h3D0098, 24'h3F0407, 24'h400003, 24'h410078,
    24'h420078, 24'h430078, 24'h440078, 24'h450000, 24'h460000, 24'h4B0000, 24'h500080, 24'h510000, 24'h52742B,
    24'h535100, 24'h544003, 24'h58207F, 24'h300000};
  always #25 ref_clk = ~ref_clk;
  idpb_block u_dut (.ref_clk(ref_clk), .reset(reset), .identify_start(identify_start), .word_take(word_take),
    .geom(geom), .serial_str(serial_str), .fwrev_str(fwrev_str), .model_str(model_str), .word_out(word_out),
    .busy(busy));
  idpb_host u_host (.ref_clk(ref_clk), .reset(reset), .slow(host_slow), .word_out(word_out), .word_take(word_take));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask : chk
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk_str(input int first, input int nw, input logic [319:0] s);
    logic [15:0] w;
    for (int i = 0; i < nw; i++) begin
      w = s[nw*16-1-16*i -: 16];
      chk(u_host.words_q[first+i], {w[15:8] == 8'h00 ? 8'h20 : w[15:8], w[7:0] == 8'h00 ? 8'h20 : w[7:0]});
    end
  endtask : chk_str
  task automatic run_block(input bit poke);
    int k;
    @(posedge ref_clk) identify_start <= 1'b1;
    @(posedge ref_clk) identify_start <= 1'b0;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
      if (poke && k == 40) begin
        @(posedge ref_clk) identify_start <= 1'b1;
        @(posedge ref_clk) identify_start <= 1'b0;
      end
    end while (busy === 1'b1 && k < 2000);
    chk(16'(k < 2000), 16'h0001);
    chk(16'(u_host.n_q), 16'h0000);
  endtask : run_block
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk(16'({busy, word_out.ready, word_out.last}), 16'h0000);
    run_block(1'b0);
    foreach (ROWS[r]) chk(u_host.words_q[ROWS[r][23:16]], ROWS[r][15:0]);
    chk_str(10, 10, serial_str);
    chk_str(23, 4, fwrev_str);
    chk_str(27, 20, model_str);
    @(posedge ref_clk);
    host_slow <= 1'b1;
    geom.multiple_valid <= 1'b0;
    geom.multiple_current <= 8'h00;
    geom.mwdma_selected <= 3'h1;
    run_block(1'b1);
    chk(u_host.words_q[0], 16'h044A);
    chk(u_host.words_q[59], 16'h0000);
    chk(u_host.words_q[63], 16'h0107);
    host_slow <= 1'b0;
    @(posedge ref_clk) identify_start <= 1'b1;
    @(posedge ref_clk) identify_start <= 1'b0;
    repeat (30) @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(16'({busy, word_out.ready}), 16'h0000);
    @(posedge ref_clk) reset <= 1'b0;
    run_block(1'b0);
    chk(u_host.words_q[58], 16'h0076);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end
endmodule : tb
bind idpb_block idpb_block_assertions #(.WORD_COUNT(WORD_COUNT)) u_chk (.ref_clk(ref_clk), .reset(reset),
  .identify_start(identify_start), .word_take(word_take), .geom(geom), .word_out(word_out), .busy(busy));
